// ### hdl/rs422_timing_pkg.sv
// constants for the two-channel synchronous rs422 timing and line-code block
// assumes a 40 MHz system clock and a 64 kbaud link clocked by the far end
package rs422_timing_pkg;
   // ****************************************************************
   // rates
   // ****************************************************************
   localparam int unsigned SYS_CLK_HZ     = 40_000_000;
   localparam int unsigned BAUD_HZ        = 64_000;
   localparam int unsigned OVERSAMPLE     = 16;
   // 40e6 / (64e3 * 16) = 39.06, so the tick runs a little fast; the loop absorbs it
   localparam int unsigned TICK_DIV       = SYS_CLK_HZ / (BAUD_HZ * OVERSAMPLE);
   localparam int unsigned TICK_W         = 6;
   localparam logic [5:0]  TICK_LAST      = 6'(TICK_DIV - 1);
   // ****************************************************************
   // dpll phase counter
   // ****************************************************************
   localparam logic [3:0]  PHASE_RESET    = 4'h0;
   localparam logic [3:0]  PHASE_SAMPLE   = 4'h7;
   localparam logic [3:0]  PHASE_LAST     = 4'hf;
   localparam logic [3:0]  PHASE_EARLY_HI = 4'h7;
   // ****************************************************************
   // fifo
   // ****************************************************************
   localparam int unsigned FIFO_DEPTH     = 32;
   localparam int unsigned CH_COUNT       = 2;
endpackage

// ### hdl/rs422_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module rs422_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // ****************************************************************
   // pointers
   // ****************************************************************
   // full is an msb mismatch with equal low bits; no spare slot is wasted
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop  ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

// ### hdl/rs422_sync_channel_timing.sv
// two-channel rs422 transmit timing and nrzi-mark receive with dpll clock recovery
// assumes tx_clk_in, rx_line are asynchronous pins; user side is on sys_clk
//
// Contract
// RULE1 - each channel runs at 64 kbaud
// RULE2 - one shared transmit-timing clock for both channels
// RULE3 - tx data changes on falling edge, mid-bit rise
// RULE4 - multiplexer send timing drives clock input
// RULE5 - both channels sampled on one send-timing clock
// RULE6 - receive nrzi-mark without far-end clock
// RULE7 - dpll at 16x bit rate aligns to edges
// RULE8 - recovered clock drives serial_comm_controller receive
// RULE9 - transition means one, no transition zero
`timescale 1ns/1ps
module rs422_sync_channel_timing #(
   parameter int CHANNELS = rs422_timing_pkg::CH_COUNT,
   parameter int DEPTH    = rs422_timing_pkg::FIFO_DEPTH
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic                tx_clk_in,
   input  wire logic [CHANNELS-1:0] tx_bits,
   input  wire logic                tx_valid,
   output logic                     tx_ready,
   output logic [CHANNELS-1:0]      tx_line,
   output logic                     tx_underrun,
   input  wire logic [CHANNELS-1:0] rx_line,
   output logic [CHANNELS-1:0]      serial_comm_controller_rx_clk,
   output logic [CHANNELS-1:0]      serial_comm_controller_rx_data
);
   // ****************************************************************
   // transmit timing clock: synchronise and find edges
   // ****************************************************************
   logic [2:0] txc_sync;
   logic [2:0] next_txc_sync;
   logic       txc_fall;
   localparam int FILL_W = $clog2(DEPTH) + 1;
   logic                tx_push;
   logic [FILL_W-1:0]   fill;
   logic [FILL_W-1:0]   next_fill;
   logic [CHANNELS-1:0] fifo_data;
   logic                fifo_valid;
   logic                fifo_pop;
   logic [CHANNELS-1:0] next_tx_line;
   logic                next_tx_underrun;
   logic                next_tx_ready;

   always_comb begin
      next_txc_sync = {txc_sync[1:0], tx_clk_in};
   end
   // reset low: a clock idling high then shows no false fall at release
   // [2] is only read after the second stage has passed it on
   assign txc_fall = txc_sync[2] && !txc_sync[1];

   // ****************************************************************
   // transmit fifo and shift-out
   // ****************************************************************
   rs422_fifo #(
      .WIDTH (CHANNELS),
      .DEPTH (DEPTH)
   ) u_tx_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_data   (tx_bits),
      .in_valid  (tx_push),
      .in_ready  (),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // one word per falling edge carries a bit of every channel on the same clock [RULE2] [RULE5]
   assign fifo_pop = txc_fall && fifo_valid;
   // a word is taken only while ready is shown
   assign tx_push  = tx_valid && tx_ready;

   always_comb begin
      next_tx_line     = tx_line;
      next_tx_underrun = tx_underrun;
      // changing on the falling edge centres the bit on the far end's rising edge [RULE3] [RULE4]
      if (txc_fall) begin
         next_tx_line     = fifo_valid ? fifo_data : {CHANNELS{1'b1}};
         next_tx_underrun = !fifo_valid;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txc_sync    <= 3'b000;
         tx_line     <= {CHANNELS{1'b1}};
         tx_underrun <= 1'b0;
      end else begin
         txc_sync    <= next_txc_sync;
         tx_line     <= next_tx_line;
         tx_underrun <= next_tx_underrun;
      end
   end

   // ****************************************************************
   // transmit fill count and ready
   // ****************************************************************
   // ready is registered, so it must already count this edge's push and pop;
   // a copy that merely lagged the fifo's own flag would promise one slot too many
   always_comb begin
      next_fill     = fill + FILL_W'(tx_push) - FILL_W'(fifo_pop);
      next_tx_ready = (next_fill != FILL_W'(DEPTH));
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill     <= '0;
         tx_ready <= 1'b0;
      end else begin
         fill     <= next_fill;
         tx_ready <= next_tx_ready;
      end
   end

   // ****************************************************************
   // 16x oversampling tick
   // ****************************************************************
   logic [5:0] tick_cnt;
   logic [5:0] next_tick_cnt;
   logic       tick;

   // 16 ticks per 64 kbaud bit [RULE1] [RULE7]
   assign tick = (tick_cnt == rs422_timing_pkg::TICK_LAST);
   always_comb begin
      next_tick_cnt = tick ? 6'h00 : tick_cnt + 6'h01;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 6'h00;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // ****************************************************************
   // dpll phase step, one call per tick
   // ****************************************************************
   // an edge in the late half means the loop lags: skip a phase; in the early half it leads: hold one
   // the sample phase is never held or skipped, so every bit is taken exactly once
   function automatic logic [3:0] dpll_step(input logic [3:0] phase_now, input logic edge_now);
      logic [3:0] step;
      step = phase_now + 4'h1;
      if (edge_now && (phase_now != rs422_timing_pkg::PHASE_RESET)) begin
         if (phase_now > rs422_timing_pkg::PHASE_EARLY_HI) begin
            step = phase_now + 4'h2;
         end else if (phase_now != rs422_timing_pkg::PHASE_SAMPLE) begin
            step = phase_now;
         end
      end
      return step;
   endfunction

   // ****************************************************************
   // per-channel receive: dpll and nrzi-mark decoder
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_rx
         logic [2:0] rx_sync;
         logic [2:0] next_rx_sync;
         logic [3:0] phase;
         logic [3:0] next_phase;
         logic       last_level;
         logic       next_last_level;
         logic       rclk;
         logic       next_rclk;
         logic       rdata;
         logic       next_rdata;
         logic       edge_seen;
         logic       edge_pend;
         logic       next_edge_pend;
         logic       edge_hit;

         assign edge_seen = rx_sync[2] != rx_sync[1];
         // the edge pulse lasts one cycle and the tick comes every 39, so it is held until the tick
         assign edge_hit  = edge_seen || edge_pend;

         always_comb begin
            next_rx_sync    = {rx_sync[1:0], rx_line[g]};
            next_phase      = phase;
            next_last_level = last_level;
            next_rdata      = rdata;
            next_rclk       = rclk;
            next_edge_pend  = edge_hit;
            if (tick) begin
               // an edge marks a bit boundary: pull phase toward zero by one step, no clock needed [RULE6] [RULE7]
               next_phase     = dpll_step(phase, edge_hit);
               next_edge_pend = 1'b0;
               if (phase == rs422_timing_pkg::PHASE_SAMPLE) begin
                  // level change since last centre is a one [RULE9]
                  next_rdata      = rx_sync[1] ^ last_level;
                  next_last_level = rx_sync[1];
               end
               // recovered clock rises one tick after the data is set up [RULE8]
               next_rclk = (phase > rs422_timing_pkg::PHASE_SAMPLE);
            end
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               rx_sync    <= 3'b111;
               phase      <= rs422_timing_pkg::PHASE_RESET;
               last_level <= 1'b1;
               rclk       <= 1'b0;
               rdata      <= 1'b0;
               edge_pend  <= 1'b0;
            end else begin
               rx_sync    <= next_rx_sync;
               phase      <= next_phase;
               last_level <= next_last_level;
               rclk       <= next_rclk;
               rdata      <= next_rdata;
               edge_pend  <= next_edge_pend;
            end
         end

         assign serial_comm_controller_rx_clk[g]  = rclk;
         assign serial_comm_controller_rx_data[g] = rdata;
      end
   endgenerate
endmodule

// ### dv/rs422_sync_channel_timing_chk.sv
// checker on the top ports of the rs422 timing block
// assumes tx_clk_in and rx_line are asynchronous pins
`timescale 1ns/1ps
module rs422_sync_channel_timing_chk #(
   parameter int CHANNELS = 2,
   parameter int DEPTH    = 32
) (
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic                tx_clk_in,
   input wire logic [CHANNELS-1:0] tx_bits,
   input wire logic                tx_valid,
   input wire logic                tx_ready,
   input wire logic [CHANNELS-1:0] tx_line,
   input wire logic                tx_underrun,
   input wire logic [CHANNELS-1:0] rx_line,
   input wire logic [CHANNELS-1:0] serial_comm_controller_rx_clk,
   input wire logic [CHANNELS-1:0] serial_comm_controller_rx_data
);
   wire rc = serial_comm_controller_rx_clk[0];
   wire rd = serial_comm_controller_rx_data[0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // properties
   // ****************************************
   sequence s_pin_fell;
      tx_clk_in ##1 !tx_clk_in;
   endsequence
   a_tx_quiet: assert property (s_pin_fell |-> $stable(tx_line)[*3])
      else $error("tx_line moved before the fall was seen");
   a_tx_when: assert property ($changed(tx_line) |-> $past(tx_clk_in, 4) && !$past(tx_clk_in, 3))
      else $error("tx_line moved away from a clock fall");
   a_tx_mid_bit: assert property ($rose(tx_clk_in) |=> $stable(tx_line)[*3])
      else $error("tx_line moved while clock high");
   a_under_when: assert property ($changed(tx_underrun) |-> $past(tx_clk_in, 4) && !$past(tx_clk_in, 3))
      else $error("tx_underrun moved away from a clock fall");
   a_under_ones: assert property (tx_underrun |-> tx_line == '1)
      else $error("underrun without idle ones");
   a_rx_clk_hold: assert property ($rose(rc) |-> rc[*8])
      else $error("recovered clock high too short");
   a_rx_data_lead: assert property ($changed(rd) |-> !rc ##1 (!rc)[*8])
      else $error("rx data moved near clock rise");
   a_rx_clk_period: assert property ($rose(rc) |-> ##[300:700] $rose(rc))
      else $error("recovered clock period off");
endmodule
bind rs422_sync_channel_timing rs422_sync_channel_timing_chk #(.CHANNELS(CHANNELS), .DEPTH(DEPTH)) i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .tx_clk_in(tx_clk_in), .tx_bits(tx_bits), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_line(tx_line), .tx_underrun(tx_underrun), .rx_line(rx_line),
   .serial_comm_controller_rx_clk(serial_comm_controller_rx_clk),
   .serial_comm_controller_rx_data(serial_comm_controller_rx_data));

// ### dv/rs422_mux_model.sv
// model of the multiplexer data module on the far side of the link
// assumes the bench starts and stops its send-timing clock through run
`timescale 1ns/1ps
module rs422_mux_model (
   output logic            tx_clk_in,
   input  wire logic [1:0] tx_line,
   output logic [1:0]      rx_line
);
   bit         run = 1;
   logic [1:0] got[$];
   // ****************************************
   // send timing and line data
   // ****************************************
   // one send-timing clock for both channels, idles high when stopped
   initial begin
      tx_clk_in = 1;
      rx_line = 2'b11;
      forever begin
         #100;
         tx_clk_in = run ? ~tx_clk_in : 1'b1;
      end
   end
   always @(posedge tx_clk_in) got.push_back(tx_line);
   // a one toggles the line, a zero holds it
   task automatic send(input logic [1:0] b);
      rx_line = rx_line ^ b;
      #15625;
   endtask
endmodule

// ### dv/rs422_sync_channel_timing_tb_top.sv
// testbench top for the rs422 timing block against the multiplexer model
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module rs422_sync_channel_timing_tb_top;
   logic        sys_clk, rst_n, tx_clk_in, tx_valid, tx_ready, tx_underrun;
   logic [1:0]  tx_bits, tx_line, rx_line, rx_clk, rx_data, rx_clk_d;
   logic [63:0] rx_sr [2];
   int          error_cnt, cmp_count, cyc;
   rs422_sync_channel_timing i_rs422_sync_channel_timing (.sys_clk(sys_clk), .rst_n(rst_n),
      .tx_clk_in(tx_clk_in), .tx_bits(tx_bits), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_line(tx_line),
      .tx_underrun(tx_underrun), .rx_line(rx_line), .serial_comm_controller_rx_clk(rx_clk),
      .serial_comm_controller_rx_data(rx_data));
   rs422_mux_model i_rs422_mux_model (.tx_clk_in(tx_clk_in), .tx_line(tx_line), .rx_line(rx_line));
   // ****************************************
   // clock, capture and checks
   // ****************************************
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // keeps a bit per recovered clock rise; a timeout counts as a mismatch
   always @(posedge sys_clk) begin
      cyc++;
      rx_clk_d <= rx_clk;
      for (int g = 0; g < 2; g++) begin
         if (rx_clk[g] === 1'b1 && rx_clk_d[g] === 1'b0) rx_sr[g] <= {rx_sr[g][62:0], rx_data[g]};
      end
      if (cyc == 40000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic t_underrun();
      repeat (20) @(posedge sys_clk);
      #2;
      chk("tx_ready", 1, tx_ready);
      chk("tx_underrun", 1, tx_underrun);
      chk("tx_line", 2'b11, tx_line);
   endtask
   // the word popped at a fall is on the line before the next rise samples it
   task automatic t_fill_drain();
      logic r;
      int   n;
      n = 0;
      i_rs422_mux_model.run = 0;
      repeat (20) @(posedge sys_clk);
      #2 tx_valid = 1;
      repeat (40) begin
         r = tx_ready;
         @(posedge sys_clk);
         if (r === 1'b1) n++;
         #2 tx_bits = n[1:0];
      end
      tx_valid = 0;
      chk("pushed", 32, n);
      chk("tx_ready", 0, tx_ready);
      i_rs422_mux_model.got.delete();
      i_rs422_mux_model.run = 1;
      repeat (100) @(posedge sys_clk);
      #2;
      chk("tx_underrun", 0, tx_underrun);
      repeat (200) @(posedge sys_clk);
      #2;
      for (int k = 0; k < 32; k++) chk("sampled", k % 4, i_rs422_mux_model.got[k]);
      chk("tx_underrun", 1, tx_underrun);
   endtask
   // ones first so the loop locks, then a pattern, then silence
   task automatic t_receive();
      logic [31:0] s0, s1;
      bit          f0, f1;
      s0 = 32'hffff_a500;
      s1 = 32'hffff_3c00;
      for (int i = 31; i >= 0; i--) i_rs422_mux_model.send({s1[i], s0[i]});
      for (int i = 0; i < 49; i++) begin
         f0 |= rx_sr[0][i +: 16] === 16'hfa50;
         f1 |= rx_sr[1][i +: 16] === 16'hf3c0;
      end
      chk("rx ch0", 1, f0);
      chk("rx ch1", 1, f1);
   endtask
   initial begin
      rst_n = 0;
      tx_valid = 0;
      tx_bits = 0;
      repeat (12) @(posedge sys_clk);
      #2 rst_n = 1;
      repeat (2) @(posedge sys_clk);
      t_underrun();
      t_fill_drain();
      t_receive();
      end_sim();
   end
endmodule
